/* File: test/sew_eeprom_slave_properties.sv */
`timescale 1ns/100ps
`default_nettype none

module sew_eeprom_slave_properties #(
  parameter integer WRITE_CYCLES = 50
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Bus side
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // Write stream and status
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic [10:0] wr_addr,
  input wire logic [7:0]  wr_data,
  input wire logic        wr_commit,
  input wire logic        rd_start,
  input wire logic        busy,
  input wire logic        standby
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Length of the current write cycle
  logic [17:0] busy_len;
  always @(posedge ref_clk) begin
    if (sys_rst || !busy)
      busy_len <= 18'h0;
    else
      busy_len <= busy_len + 18'h1;
  end

  a_oe_drives_low: assert property (sda_oe |-> !sda_out)
    else $error("ack slot not driven low");
  a_ack_one_slot: assert property ($rose(sda_oe) |-> ##[1:40] !sda_oe)
    else $error("ack held too long");
  a_commit_sets_busy: assert property (wr_commit |=> busy)
    else $error("commit without busy");
  a_commit_one_pulse: assert property (wr_commit |=> !wr_commit)
    else $error("commit wider than one cycle");
  a_busy_exact_len: assert property ($fell(busy) |-> busy_len == WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_busy_no_ack: assert property ($rose(sda_oe) |-> !busy)
    else $error("ack while busy");
  a_busy_not_idle: assert property (busy && $past(busy) |-> !standby)
    else $error("standby while busy");
  a_word_held: assert property (wr_valid && !wr_ready |=>
      wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("stalled word changed");
  a_read_pulse: assert property (rd_start |=> !rd_start)
    else $error("read start wider than one cycle");

  c_commit: cover property (wr_commit);
  c_read: cover property (rd_start);
  c_cycle_end: cover property ($fell(busy));
  c_stall: cover property (wr_valid && !wr_ready);
endmodule // sew_eeprom_slave_properties

bind sew_eeprom_slave sew_eeprom_slave_properties #(
  .WRITE_CYCLES(WRITE_CYCLES)
) i_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .sda_out(sda_out),
  .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_addr(wr_addr), .wr_data(wr_data), .wr_commit(wr_commit),
  .rd_start(rd_start), .busy(busy), .standby(standby)
);

`default_nettype wire

/* File: test/sew_eeprom_slave_test.sv */
`timescale 1ns/100ps
`default_nettype none

module sew_eeprom_slave_test;
  localparam integer WCYC = 200;
  logic        ref_clk, sys_rst, wr_ready, cs_h, cs_m, cs_l;
  wire logic   scl, sda_low, sda_out, sda_oe, sda;
  wire logic   wr_valid, wr_commit, wr_abort, busy, standby, rd_start;
  wire logic [10:0] wr_addr, word_addr;
  wire logic [7:0]  wr_data;
  logic [18:0] got[$];
  int          mismatches, checked, rd_cnt, ab_cnt, cm_cnt;

  assign sda = !(sda_low || (sda_oe && !sda_out));

  sew_master_model i_master (.scl(scl), .sda_low(sda_low), .sda_line(sda));
  sew_eeprom_slave #(.WRITE_CYCLES(WCYC)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_high_pin(cs_h),
    .chip_select_mid_pin(cs_m), .chip_select_low_pin(cs_l),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_commit(wr_commit), .wr_abort(wr_abort),
    .busy(busy), .standby(standby), .rd_start(rd_start),
    .word_addr(word_addr));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = !ref_clk;
  end

  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      got.push_back({wr_addr, wr_data});
    if (rd_start === 1'b1)
      rd_cnt++;
    if (wr_abort === 1'b1)
      ab_cnt++;
    if (wr_commit === 1'b1)
      cm_cnt++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Waits n edges and steps just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [7:0] dev(input logic [2:0] b, input logic rw);
    return {1'b1, cs_h, !cs_m, cs_l, b, rw};
  endfunction

  task automatic hdr(input logic [2:0] b, input logic [7:0] wa);
    logic a;
    i_master.start();
    i_master.send_byte(dev(b, 1'b0), a);
    chk(a, 1);
    i_master.send_byte(wa, a);
    chk(a, 1);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 1000) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic t_byte_poll;
    logic a;
    int   n;
    got.delete();
    hdr(3'h5, 8'h3C);
    i_master.send_byte(8'hA7, a);
    chk(a, 1);
    i_master.stop();
    tick(8);
    chk(busy, 1);
    chk(standby, 0);
    chk(cm_cnt, 1);
    chk(got.size(), 1);
    chk(got[0], {3'h5, 8'h3C, 8'hA7});
    chk(word_addr, {3'h5, 8'h3D});
    n = 0;
    a = 1'b0;
    while (!a && n < 8) begin
      i_master.start();
      i_master.send_byte(dev(3'h0, 1'b0), a);
      n++;
    end
    i_master.stop();
    chk(n > 1, 1);
    chk(a, 1);
    chk(busy, 0);
    $display("byte write and polling done");
  endtask

  task automatic t_page;
    logic a;
    got.delete();
    hdr(3'h2, 8'hFE);
    for (int i = 0; i < 18; i++) begin
      i_master.send_byte(8'(i), a);
      chk(a, 1);
    end
    i_master.stop();
    tick(8);
    chk(got.size(), 18);
    for (int i = 0; i < 18; i++)
      chk(got[i], {7'h2F, 4'(4'hE + i), 8'(i)});
    chk(word_addr, {3'h2, 8'hF0});
    wait_idle();
    $display("page write done");
  endtask

  task automatic t_refuse;
    logic       a;
    logic [7:0] bad[3];
    bad = '{{1'b1, cs_h, cs_m, cs_l, 4'h0}, {1'b0, cs_h, !cs_m, cs_l, 4'h0},
            {1'b1, cs_h, !cs_m, !cs_l, 4'h0}};
    foreach (bad[i]) begin
      i_master.start();
      i_master.send_byte(bad[i], a);
      chk(a, 0);
      i_master.stop();
      tick(4);
      chk(standby, 1);
    end
    $display("address refusal done");
  endtask

  task automatic t_read_abort;
    logic a;
    i_master.start();
    i_master.send_byte(dev(3'h1, 1'b1), a);
    chk(a, 1);
    chk(rd_cnt, 1);
    hdr(3'h0, 8'h10);
    i_master.send_byte(8'h55, a);
    chk(a, 1);
    i_master.start();
    chk(ab_cnt, 1);
    i_master.send_byte(dev(3'h0, 1'b0), a);
    chk(a, 1);
    i_master.stop();
    tick(8);
    chk(busy, 0);
    chk(cm_cnt, 2);
    $display("read and abort done");
  endtask

  task automatic t_fill;
    logic a;
    got.delete();
    @(posedge ref_clk);
    #1 wr_ready = 1'b0;
    hdr(3'h4, 8'h00);
    // Eight buffered words plus the drain register are acked, then refused
    for (int i = 0; i < 10; i++) begin
      i_master.send_byte(8'h80 + 8'(i), a);
      chk(a, i < 9);
    end
    i_master.stop();
    chk(wr_valid, 1);
    @(posedge ref_clk);
    #1 wr_ready = 1'b1;
    tick(20);
    chk(got.size(), 9);
    chk(got[8], {3'h4, 8'h08, 8'h88});
    chk(cm_cnt, 3);
    wait_idle();
    $display("buffer fill done");
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    mismatches = 0;
    checked = 0;
    rd_cnt = 0;
    ab_cnt = 0;
    cm_cnt = 0;
    sys_rst = 1'b1;
    wr_ready = 1'b1;
    cs_h = 1'b1;
    cs_m = 1'b0;
    cs_l = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    tick(4);
    chk(standby, 1);
    i_master.recover();
    i_master.stop();
    t_byte_poll();
    t_page();
    t_refuse();
    t_read_abort();
    t_fill();
    end_sim();
  end
endmodule // sew_eeprom_slave_test

`default_nettype wire

/* File: test/sew_master_model.sv */
`timescale 1ns/100ps
`default_nettype none

module sew_master_model (
  // Bus lines, data is open drain
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  localparam time Q = 100;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic bit_slot(input logic b, output logic s);
    sda_low = !b;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda_line;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic start;
    sda_low = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic stop;
    sda_low = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], s);
    end
    bit_slot(1'b1, s);
    ack = !s;
  endtask

  task automatic recover;
    logic s;
    repeat (9) bit_slot(1'b1, s);
    start();
  endtask
endmodule // sew_master_model

`default_nettype wire

/* File: verilog/sew_eeprom_slave.v */
`timescale 1ns/100ps
`default_nettype none
`include "sew_regs.vh"


module sew_eeprom_slave #(
  parameter integer WRITE_CYCLES = `SEW_NVW_TIME_MS * `SEW_CLK_KHZ,
  parameter integer FIFO_DEPTH   = `SEW_FIFO_DEPTH
) (
  // Clock and reset
  input  wire                   ref_clk,
  input  wire                   sys_rst,
  // Two-wire bus
  input  wire                   scl_in,
  input  wire                   sda_in,
  output reg                    sda_out,
  output reg                    sda_oe,
  // Chip-select straps
  input  wire                   chip_select_high_pin,
  input  wire                   chip_select_mid_pin,
  input  wire                   chip_select_low_pin,
  // Write stream towards the page latch
  output wire                   wr_valid,
  input  wire                   wr_ready,
  output wire [`SEW_ADDR_W-1:0] wr_addr,
  output wire [`SEW_BYTE_W-1:0] wr_data,
  // Write cycle control
  output reg                    wr_commit,
  output reg                    wr_abort,
  output reg                    busy,
  // Status and hand-over to read logic
  output reg                    standby,
  output reg                    rd_start,
  output reg  [`SEW_ADDR_W-1:0] word_addr
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DEV  = 3'h1;
  localparam [2:0] ST_WORD = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_READ = 3'h4;

  localparam integer BW  = `SEW_BUSY_W;
  localparam integer FW  = `SEW_ADDR_W + `SEW_BYTE_W;
  localparam [31:0]  WC  = WRITE_CYCLES;
  // Cut to the counter width; the full write time fits in it
  localparam [BW-1:0] BUSY_LOAD = WC[BW-1:0];

  // Synchronised pins
  wire       scl_s;
  wire       sda_s;
  wire [2:0] cs_s;

  // Pins idle high; reset to that level so no false start follows reset
  sew_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_bus_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({scl_in, sda_in}),
    .sync_out ({scl_s, sda_s})
  );

  sew_sync #(
    .W       (3),
    .RST_VAL (3'h0)
  ) u_cs_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({chip_select_high_pin, chip_select_mid_pin,
                chip_select_low_pin}),
    .sync_out (cs_s)
  );

  // Previous sampled levels for edge finding
  reg scl_q;
  reg sda_q;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

  // Address word compare
  function addr_match;
    input [7:0] dev;
    input [2:0] cs;
    begin
      addr_match = dev[`SEW_DEV_FIXED_BIT] &
                   (dev[`SEW_DEV_CS_HIGH_BIT] == cs[2]) &
                   (dev[`SEW_DEV_CS_MID_BIT] == ~cs[1]) &
                   (dev[`SEW_DEV_CS_LOW_BIT] == cs[0]);
    end
  endfunction

  // Protocol state
  reg [2:0]              state;
  reg [3:0]              bit_cnt;
  reg [7:0]              shift;
  reg                    ack_phase;
  reg [2:0]              block;
  reg                    wrote;
  reg [BW-1:0]           busy_cnt;

  wire [7:0] next_shift = {shift[6:0], sda_s};

  // Push of a received data byte into the buffer
  wire fifo_ready;
  reg  push;
  reg  [FW-1:0] push_word;

  // Fall after the eighth bit opens the ack slot; a refused byte parks the
  // counter here until the next start
  wire byte_done = scl_fall & ~ack_phase & (bit_cnt == `SEW_ACK_SLOT);

  always @* begin
    push      = 1'b0;
    push_word = {word_addr, shift};
    if (byte_done && (state == ST_DATA) && fifo_ready) begin
      push = 1'b1;
    end
  end

  // The drain register holds one word on top of the buffer depth
  sew_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

  // Bit counter and shift register
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
    end else if (bus_start) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise && !ack_phase && bit_cnt != `SEW_ACK_SLOT) begin
      shift   <= next_shift;
      bit_cnt <= bit_cnt + 4'h1;
    end else if (scl_fall && ack_phase) begin
      bit_cnt <= 4'h0;
    end
  end

  // Main protocol sequencer
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      ack_phase <= 1'b0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
      block     <= 3'h0;
      rd_start  <= 1'b0;
    end else begin
      rd_start <= 1'b0;
      if (bus_start) begin
        state     <= ST_DEV;
        ack_phase <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        state     <= ST_IDLE;
        ack_phase <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (scl_fall && ack_phase) begin
        ack_phase <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (byte_done) begin
        case (state)
          ST_IDLE: begin
            // Bytes meant for other devices are ignored
            state <= ST_IDLE;
          end
          ST_DEV: begin
            if (addr_match(shift, cs_s) && !busy) begin
              ack_phase <= 1'b1;
              sda_oe    <= 1'b1;
              block     <= shift[`SEW_DEV_BLOCK_MSB:`SEW_DEV_BLOCK_LSB];
              if (shift[`SEW_DEV_RW_BIT]) begin
                state    <= ST_READ;
                rd_start <= 1'b1;
              end else begin
                state <= ST_WORD;
              end
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_WORD: begin
            ack_phase <= 1'b1;
            sda_oe    <= 1'b1;
            state     <= ST_DATA;
          end
          ST_DATA: begin
            if (fifo_ready) begin
              ack_phase <= 1'b1;
              sda_oe    <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_READ: begin
            // Read data belongs to the read logic; this side only waits
            state <= ST_READ;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Word address counter
  // Kept across transfers so the read logic can continue from it
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      word_addr <= {`SEW_ADDR_W{1'b0}};
    end else if (byte_done && state == ST_WORD) begin
      word_addr <= {block, shift};
    end else if (push) begin
      word_addr <= {word_addr[`SEW_ADDR_W-1:`SEW_PAGE_BITS],
                    word_addr[`SEW_PAGE_BITS-1:0] + 4'h1};
    end
  end

  // Tracks whether the current write sequence holds data
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wrote     <= 1'b0;
      wr_commit <= 1'b0;
      wr_abort  <= 1'b0;
    end else begin
      wr_commit <= 1'b0;
      wr_abort  <= 1'b0;
      if (bus_stop && wrote) begin
        wr_commit <= 1'b1;
        wrote     <= 1'b0;
      end else if (bus_start && wrote) begin
        // A restart drops the partly received page
        wr_abort <= 1'b1;
        wrote    <= 1'b0;
      end else if (push) begin
        wrote <= 1'b1;
      end
    end
  end

  // Self-timed write cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      busy     <= 1'b0;
      busy_cnt <= {BW{1'b0}};
    end else if (bus_stop && wrote) begin
      busy     <= 1'b1;
      busy_cnt <= BUSY_LOAD;
    end else if (busy) begin
      // Polls stay refused until the count runs out
      busy_cnt <= busy_cnt - 1'b1;
      if (busy_cnt == {{(BW-1){1'b0}}, 1'b1}) begin
        busy <= 1'b0;
      end
    end
  end

  // Standby once idle and no write cycle pending
  // A start, or a stop that ends a write, seen this cycle already counts as bus activity
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      standby <= 1'b1;
    end else begin
      standby <= (state == ST_IDLE) & ~busy & ~(bus_stop & wrote) &
                 ~bus_start;
    end
  end

endmodule // sew_eeprom_slave

`default_nettype wire

/* File: verilog/sew_fifo.v */
`timescale 1ns/100ps
`default_nettype none

module sew_fifo #(
  parameter integer W     = 19,
  parameter integer DEPTH = 8,
  parameter integer AW    = 3
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         sys_rst,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side, registered
  output reg          out_valid,
  input  wire         out_ready,
  output reg  [W-1:0] out_data
);

  localparam [AW:0] DEPTH_C = DEPTH[AW:0];

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;

  wire push = in_valid & in_ready;
  // Refill the output stage when it is empty or being taken
  wire pop  = (count != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  assign in_ready = (count != DEPTH_C);

  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr   <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
      if (pop) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule // sew_fifo

`default_nettype wire

/* File: verilog/sew_regs.vh */
`ifndef SEW_REGS_VH
`define SEW_REGS_VH

// System clock rate in kHz
`define SEW_CLK_KHZ 20000
// Self-timed nonvolatile write time in ms
`define SEW_NVW_TIME_MS 10
// Width of the write-cycle counter
`define SEW_BUSY_W 18

// Device address word layout
`define SEW_DEV_FIXED_BIT 7
`define SEW_DEV_CS_HIGH_BIT 6
`define SEW_DEV_CS_MID_BIT 5
`define SEW_DEV_CS_LOW_BIT 4
`define SEW_DEV_BLOCK_MSB 3
`define SEW_DEV_BLOCK_LSB 1
`define SEW_DEV_RW_BIT 0

// Word sizes
`define SEW_BYTE_W 8
`define SEW_ADDR_W 11
`define SEW_PAGE_BITS 4
`define SEW_ACK_SLOT 4'h8

// Write stream buffer
`define SEW_FIFO_DEPTH 8

`endif

/* File: verilog/sew_sync.v */
`timescale 1ns/100ps
`default_nettype none

module sew_sync #(
  parameter integer W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         sys_rst,
  // Asynchronous levels in, synchronised levels out
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sew_sync

`default_nettype wire
